// ---- core/rsrtc_pkg.sv ----
// Purpose: shared constants and types of the socket timekeeper
// Assumes: 200 MHz reference clock
// Notes: time image bit n is serial bit n, register 0 in the low byte
package rsrtc_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 32;

  // ************************************************************
  // sequence
  // ************************************************************
  localparam int SEQ_BITS = 64;
  localparam int PTR_W = 6;
  localparam logic [PTR_W-1:0] PTR_LAST = 6'h3F;
  localparam logic [PTR_W-1:0] PTR_FIRST = 6'h00;
  // bytes c5 3a a3 5c twice, byte 0 in the low bits
  localparam logic [SEQ_BITS-1:0] UNLOCK_PATTERN = 64'h5CA33AC55CA33AC5;

  // ************************************************************
  // register fields
  // ************************************************************
  localparam int HOUR_MODE12_BIT = 7;
  localparam int HOUR_PM_BIT = 5;
  localparam int DAY_RESET_GATE_BIT = 4;
  localparam int DAY_OSC_OFF_BIT = 5;
  localparam logic [7:0] HOUR24_LAST = 8'h23;
  localparam logic [7:0] HOUR12_LAST = 8'h12;
  localparam logic [7:0] HOUR12_PRE = 8'h11;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] HSEC_LAST = 8'h99;
  localparam logic [7:0] WDAY_LAST = 8'h07;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // bits that always read zero are cleared on every load
  localparam logic [SEQ_BITS-1:0] TIME_KEEP_MASK = 64'hFF1F3F37BF7F7FFF;
  localparam logic [SEQ_BITS-1:0] TIME_RESET = 64'h0001010100000000;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
    logic [7:0] hsec;
  } rsrtc_time_type;

  typedef struct packed {
    logic is_read;
    logic data;
  } rsrtc_event_type;

  typedef enum logic [2:0] {
    ST_MATCH = 3'b001,
    ST_XFER = 3'b010,
    ST_COMMIT = 3'b100
  } rsrtc_state_type;
endpackage

// ---- core/rsrtc_sync.sv ----
// Purpose: two flop synchroniser for pin levels
// Assumes: inputs are asynchronous to I_REF_CLK
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module rsrtc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule

// ---- core/rsrtc_fifo.sv ----
// Purpose: small buffer with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: flush empties it at once
`timescale 1ns/100ps
module rsrtc_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
endmodule

// ---- core/rsrtc_top.sv ----
// Purpose: timekeeper hidden in a memory socket, reached by read cycles
// Assumes: one reference clock; all pins asynchronous
// Notes: time advances every TICK_CYCLES clocks while the oscillator runs
// Overview of operation
// - all transfers ride on read cycles to the mated memory range.
// - direction line low writes the data-in bit, high reads onto data-out.
// - a cycle runs while both enables are low; either edge frames it.
// - access opens only after 64 matching serial write cycles.
// - first write is checked against bit 0; a match advances the pointer.
// - a mismatch freezes the pointer and later writes are ignored.
// - any read during matching aborts and rewinds the pointer.
// - pattern is C5 3A A3 5C twice, least significant bit first.
// - after unlock, 64 cycles move time bits in or out per direction.
// - cycles outside the mated range do not disturb either sequence.
// - mated memory chip enable is withheld while the sequences run.
// - enabled reset pin aborts access, registers kept; I_RST also loads TIME_RESET.
// - power-fail ignores socket cycles and aborts like the reset pin; I_CE_N still reaches O_MEM_CE_N.
// - eight 8-bit registers move from bit 0 of reg 0 to bit 7 of reg 7.
// - all time values are held in BCD.
// - hours bit 7 picks 12-hour mode; bit 5 is PM or tens-of-hours.
// - day bit 4 set ignores the reset pin; clear lets it abort.
// - day bit 5 set stops the oscillator and timekeeping.
// - unused bits of registers 1 to 6 read zero, writes accepted.
// - registers are hundredths, seconds, minutes, hours, weekday, date, month, year.
// - date rolls over on short months and leap-year February.
// - hundredths advance every ten milliseconds.
`timescale 1ns/100ps
module rsrtc_top #(
  parameter int TICK_CYCLES = rsrtc_pkg::TICK_CYCLES
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE_N,
  input wire logic I_OE_N,
  input wire logic I_DIRECTION_SELECT_LINE,
  input wire logic I_SERIAL_WRITE_BIT_LINE,
  input wire logic I_UPPER_ADDRESS_RESET_N,
  input wire logic I_POWER_FAIL,
  output logic O_SERIAL_READ_BIT_LINE,
  output logic O_SERIAL_READ_BIT_LINE_OE_N,
  output logic O_MEM_CE_N,
  output logic O_UNLOCKED,
  output logic O_OSC_RUNNING
);
  import rsrtc_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [5:0] pins_s;
  logic ce_s;
  logic oe_s;
  logic dir_s;
  logic din_s;
  logic rstpin_s;
  logic pfail_s;

  rsrtc_sync #(.WIDTH(6), .RESET_VAL(6'h2B)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_async({I_CE_N, I_POWER_FAIL, I_OE_N, I_DIRECTION_SELECT_LINE,
              I_UPPER_ADDRESS_RESET_N, I_SERIAL_WRITE_BIT_LINE}),
    .o_sync(pins_s)
  );
  assign ce_s = pins_s[5];
  assign pfail_s = pins_s[4];
  assign oe_s = pins_s[3];
  assign dir_s = pins_s[2];
  assign rstpin_s = pins_s[1];
  assign din_s = pins_s[0];

  // ************************************************************
  // abort and cycle framing
  // ************************************************************
  rsrtc_time_type tk;
  rsrtc_time_type shadow;
  rsrtc_state_type state;
  logic abort;
  logic active;
  logic active_q;
  logic cyc_start;
  logic cyc_end;
  logic cyc_dir;
  logic cyc_bit;
  logic pend;
  rsrtc_event_type ev_in;
  rsrtc_event_type ev;
  logic ev_in_ready;
  logic ev_valid;
  logic ev_ready;

  assign abort = pfail_s | (~rstpin_s & ~tk.wday[DAY_RESET_GATE_BIT]);
  assign active = ~ce_s & ~oe_s & ~pfail_s;
  assign cyc_start = active & ~active_q;
  assign cyc_end = ~active & active_q;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active;
    end
  end

  // direction and data-in are taken when the cycle opens
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cyc_dir <= 1'b1;
      cyc_bit <= 1'b0;
    end else if (cyc_start) begin
      cyc_dir <= dir_s;
      cyc_bit <= din_s;
    end
  end

  // finished cycle waits here until the buffer takes it
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend <= 1'b0;
    end else if (abort) begin
      pend <= 1'b0;
    end else if (cyc_end) begin
      pend <= 1'b1;
    end else if (ev_in_ready) begin
      pend <= 1'b0;
    end
  end

  assign ev_in.is_read = cyc_dir;
  assign ev_in.data = cyc_bit;

  rsrtc_fifo #(.WIDTH($bits(rsrtc_event_type)), .DEPTH(2)) u_buf (
    .i_clk(I_REF_CLK),
    .i_rst(I_RST),
    .i_flush(abort),
    .i_valid(pend),
    .o_ready(ev_in_ready),
    .i_data(ev_in),
    .o_valid(ev_valid),
    .i_ready(ev_ready),
    .o_data(ev)
  );

  // ************************************************************
  // unlock and transfer sequencer
  // ************************************************************
  logic [PTR_W-1:0] ptr;
  logic failed;
  logic dirty;
  logic take;

  // the commit cycle stalls the buffer
  assign ev_ready = (state != ST_COMMIT);
  assign take = ev_valid & ev_ready;

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state <= ST_MATCH;
      ptr <= PTR_FIRST;
      failed <= 1'b0;
    end else if (abort) begin
      state <= ST_MATCH;
      ptr <= PTR_FIRST;
      failed <= 1'b0;
    end else begin
      case (state)
        ST_MATCH: begin
          if (take && ev.is_read) begin
            ptr <= PTR_FIRST;
            failed <= 1'b0;
          end else if (take && !failed) begin
            if (ev.data == UNLOCK_PATTERN[ptr]) begin
              if (ptr == PTR_LAST) begin
                state <= ST_XFER;
                ptr <= PTR_FIRST;
              end else begin
                ptr <= ptr + PTR_W'(1);
              end
            end else begin
              failed <= 1'b1;
            end
          end
        end
        ST_XFER: begin
          if (take) begin
            if (ptr == PTR_LAST) begin
              state <= ST_COMMIT;
              ptr <= PTR_FIRST;
            end else begin
              ptr <= ptr + PTR_W'(1);
            end
          end
        end
        ST_COMMIT: begin
          state <= ST_MATCH;
        end
        default: begin
          state <= ST_MATCH;
        end
      endcase
    end
  end

  // snapshot at unlock; written bits replace it in order
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      shadow <= TIME_RESET;
      dirty <= 1'b0;
    end else if (state == ST_MATCH) begin
      shadow <= tk;
      dirty <= 1'b0;
    end else if (state == ST_XFER && take && !ev.is_read) begin
      shadow[ptr] <= ev.data;
      dirty <= 1'b1;
    end
  end

  // ************************************************************
  // data-out pin and mated memory enable
  // ************************************************************
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_SERIAL_READ_BIT_LINE <= 1'b0;
      O_SERIAL_READ_BIT_LINE_OE_N <= 1'b1;
    end else if (abort || cyc_end) begin
      O_SERIAL_READ_BIT_LINE_OE_N <= 1'b1;
    end else if (cyc_start && dir_s && state == ST_XFER) begin
      O_SERIAL_READ_BIT_LINE <= shadow[ptr];
      O_SERIAL_READ_BIT_LINE_OE_N <= 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MEM_CE_N <= 1'b1;
    end else begin
      O_MEM_CE_N <= ce_s | (state != ST_MATCH)
                    | (ptr != PTR_FIRST && !failed);
    end
  end

  assign O_UNLOCKED = (state == ST_XFER);
  assign O_OSC_RUNNING = ~tk.wday[DAY_OSC_OFF_BIT];

  // ************************************************************
  // timekeeping
  // ************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = ~y[0] & (y[4] == y[1]);
    if (m == 8'h02) begin
      month_end = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      month_end = 8'h30;
    end else begin
      month_end = 8'h31;
    end
  endfunction

  logic [TICK_CNT_W-1:0] presc;
  logic tick;

  assign tick = (presc == TICK_CNT_W'(TICK_CYCLES - 1));

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      presc <= '0;
    end else if (tk.wday[DAY_OSC_OFF_BIT]) begin
      presc <= '0;
    end else if (tick) begin
      presc <= '0;
    end else begin
      presc <= presc + TICK_CNT_W'(1);
    end
  end

  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_day;
  logic c_month;
  logic [7:0] next_hour;

  assign c_sec = (tk.hsec == HSEC_LAST);
  assign c_min = c_sec && (tk.sec == SEC_LAST);
  assign c_hour = c_min && (tk.min == SEC_LAST);
  assign c_day = c_hour && (tk.hour[HOUR_MODE12_BIT]
                 ? (tk.hour[HOUR_PM_BIT] && tk.hour[4:0] == HOUR12_PRE[4:0])
                 : (tk.hour == HOUR24_LAST));
  assign c_month = c_day && (tk.date == month_end(tk.month, tk.year));

  always_comb begin
    next_hour = tk.hour;
    if (tk.hour[HOUR_MODE12_BIT]) begin
      if (tk.hour[4:0] == HOUR12_LAST[4:0]) begin
        next_hour[4:0] = BCD_ONE[4:0];
      end else begin
        next_hour[4:0] = 5'(bcd_inc({3'h0, tk.hour[4:0]}));
      end
      if (tk.hour[4:0] == HOUR12_PRE[4:0]) begin
        next_hour[HOUR_PM_BIT] = ~tk.hour[HOUR_PM_BIT];
      end
    end else if (tk.hour == HOUR24_LAST) begin
      next_hour = 8'h00;
    end else begin
      next_hour = bcd_inc({2'h0, tk.hour[5:0]});
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      tk <= TIME_RESET;
    end else if (state == ST_COMMIT && dirty && !abort) begin
      tk <= shadow & TIME_KEEP_MASK;
    end else if (tick && !tk.wday[DAY_OSC_OFF_BIT]) begin
      tk.hsec <= c_sec ? 8'h00 : bcd_inc(tk.hsec);
      if (c_sec) begin
        tk.sec <= c_min ? 8'h00 : bcd_inc(tk.sec);
      end
      if (c_min) begin
        tk.min <= c_hour ? 8'h00 : bcd_inc(tk.min);
      end
      if (c_hour) begin
        tk.hour <= next_hour;
      end
      if (c_day) begin
        tk.wday[2:0] <= (tk.wday[2:0] == WDAY_LAST[2:0]) ? BCD_ONE[2:0]
                        : tk.wday[2:0] + 3'h1;
        tk.date <= c_month ? BCD_ONE : bcd_inc(tk.date);
      end
      if (c_month) begin
        tk.month <= (tk.month == MONTH_LAST) ? BCD_ONE : bcd_inc(tk.month);
        if (tk.month == MONTH_LAST) begin
          tk.year <= (tk.year == YEAR_LAST) ? 8'h00 : bcd_inc(tk.year);
        end
      end
    end
  end
endmodule

// ---- bench/rsrtc_monitor.sv ----
// Purpose: port checks of the socket timekeeper
// Assumes: sees only the top ports
// Notes: bound from the bench top
`timescale 1ns/100ps
module rsrtc_monitor #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_CE_N,
  input wire logic I_OE_N,
  input wire logic I_DIRECTION_SELECT_LINE,
  input wire logic I_SERIAL_WRITE_BIT_LINE,
  input wire logic I_UPPER_ADDRESS_RESET_N,
  input wire logic I_POWER_FAIL,
  input wire logic O_SERIAL_READ_BIT_LINE,
  input wire logic O_SERIAL_READ_BIT_LINE_OE_N,
  input wire logic O_MEM_CE_N,
  input wire logic O_UNLOCKED,
  input wire logic O_OSC_RUNNING
);
  // ********
  // assertions
  // ********
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  sequence s_close;
    $rose(I_CE_N) || $rose(I_OE_N);
  endsequence
  sequence s_pf_held;
    I_POWER_FAIL [*6];
  endsequence
  a_read_opens: assert property ($fell(O_SERIAL_READ_BIT_LINE_OE_N) |->
    $past(!I_CE_N && !I_OE_N && I_DIRECTION_SELECT_LINE, 2)) else $error("drive without read");
  a_read_unlocked: assert property (
    $fell(O_SERIAL_READ_BIT_LINE_OE_N) |-> O_UNLOCKED) else $error("drive while locked");
  a_pin_release: assert property (s_close |-> ##[1:5] O_SERIAL_READ_BIT_LINE_OE_N)
    else $error("data pin held after close");
  a_data_stands: assert property (
    !O_SERIAL_READ_BIT_LINE_OE_N && $past(!O_SERIAL_READ_BIT_LINE_OE_N)
    |-> $stable(O_SERIAL_READ_BIT_LINE)) else $error("data changed mid cycle");
  a_mem_detached: assert property (O_UNLOCKED |-> O_MEM_CE_N)
    else $error("memory enabled during transfer");
  a_mem_follows: assert property ($fell(O_MEM_CE_N) |->
    !$past(I_CE_N, 3) || !$past(I_CE_N, 4)) else $error("memory enable without cause");
  a_mem_closes: assert property ($rose(I_CE_N) |-> ##[1:4] O_MEM_CE_N)
    else $error("memory enable stuck low");
  a_pf_aborts: assert property (
    s_pf_held |-> !O_UNLOCKED && O_SERIAL_READ_BIT_LINE_OE_N) else $error("power fail ignored");
  a_osc_commit: assert property ($changed(O_OSC_RUNNING) |->
    $past(O_UNLOCKED) || $past(O_UNLOCKED, 2) || $past(O_UNLOCKED, 3) || $past(O_UNLOCKED, 4))
    else $error("oscillator changed without commit");
endmodule

// ---- bench/rsrtc_host_model.sv ----
// Purpose: host bus issuing read cycles into the socket
// Assumes: tasks called from the bench at falling edges
// Notes: never issues write strobes into the socket range
`timescale 1ns/100ps
module rsrtc_host_model (
  input wire logic i_clk,
  input wire logic i_dq,
  input wire logic i_dq_oe_n,
  input wire logic i_mem_ce_n,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_dir,
  output logic o_wbit
);
  // ********
  // socket cycles
  // ********
  initial begin
    o_ce_n = 1'h1;
    o_oe_n = 1'h1;
    o_dir = 1'h1;
    o_wbit = 1'h0;
  end
  // mine low leaves chip enable high: a cycle to other memory
  task automatic cyc(input logic mine, input logic d, input logic b, output logic r,
      output logic m);
    @(negedge i_clk);
    o_ce_n = ~mine;
    o_oe_n = 1'h0;
    o_dir = d;
    o_wbit = b;
    repeat (6) @(negedge i_clk);
    // undriven line shows the inverse level
    r = i_dq_oe_n ? ~i_dq : i_dq;
    m = i_mem_ce_n;
    o_ce_n = 1'h1;
    o_oe_n = 1'h1;
    o_dir = ~d;
    o_wbit = ~b;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

// ---- bench/tb_rom_socket_serial_rtc.sv ----
// Purpose: self-checking bench of the socket timekeeper
// Assumes: short tick for simulation
// Notes: host model drives the socket pins
`timescale 1ns/100ps
module tb_rom_socket_serial_rtc;
  import rsrtc_pkg::*;
  localparam int TICKS = 20;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic pin_rst_n = 1'h1;
  logic pf = 1'h0;
  logic ce_n, oe_n, dir, wbit, dq, dq_oe_n, mem_ce_n, unlocked, osc_on, r, m;
  int bad_count = 0;
  int tests_run = 0;
  rsrtc_time_type t_w, t_r;
  always #2.5 clk = ~clk;
  rsrtc_top #(.TICK_CYCLES(TICKS)) uut (.I_REF_CLK(clk), .I_RST(rst), .I_CE_N(ce_n),
    .I_OE_N(oe_n), .I_DIRECTION_SELECT_LINE(dir), .I_SERIAL_WRITE_BIT_LINE(wbit),
    .I_UPPER_ADDRESS_RESET_N(pin_rst_n), .I_POWER_FAIL(pf), .O_SERIAL_READ_BIT_LINE(dq),
    .O_SERIAL_READ_BIT_LINE_OE_N(dq_oe_n), .O_MEM_CE_N(mem_ce_n), .O_UNLOCKED(unlocked),
    .O_OSC_RUNNING(osc_on));
  rsrtc_host_model host (.i_clk(clk), .i_dq(dq), .i_dq_oe_n(dq_oe_n), .i_mem_ce_n(mem_ce_n),
    .o_ce_n(ce_n), .o_oe_n(oe_n), .o_dir(dir), .o_wbit(wbit));
  // ********
  // helpers
  // ********
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction
  function automatic rsrtc_time_type rand_time(input logic [7:0] ctl);
    rsrtc_time_type t;
    t.hsec = bcd($urandom % 100);
    t.sec = bcd($urandom % 60);
    t.min = bcd($urandom % 60);
    t.hour = bcd($urandom % 24);
    t.wday = ctl;
    t.date = bcd(1 + $urandom % 28);
    t.month = bcd(1 + $urandom % 12);
    t.year = bcd($urandom % 100);
    return t;
  endfunction
  function automatic logic digits_ok(input rsrtc_time_type t);
    digits_ok = 1'h1;
    for (int i = 0; i < 8; i++) begin
      if (t[8*i +: 4] > 4'h9) digits_ok = 1'h0;
    end
  endfunction
  // rewind read, then key bits with a foreign cycle now and then
  task automatic key(input int upto, input int flip);
    host.cyc(1'h1, 1'h1, 1'h0, r, m);
    for (int i = 0; i < upto; i++) begin
      if (i % 16 == 7) host.cyc(1'h0, 1'h0, 1'($urandom), r, m);
      host.cyc(1'h1, 1'h0, UNLOCK_PATTERN[i] ^ (i == flip), r, m);
    end
  endtask
  task automatic xfer(input logic rd, input rsrtc_time_type t, output rsrtc_time_type q);
    int held;
    held = 0;
    for (int i = 0; i < SEQ_BITS; i++) begin
      if (i % 16 == 9) host.cyc(1'h0, 1'h1, 1'h0, r, m);
      host.cyc(1'h1, rd, t[i], r, m);
      q[i] = r;
      held += int'(m);
    end
    chk(held, SEQ_BITS);
  endtask
  task automatic pin_reset();
    pin_rst_n = 1'h0;
    repeat (8) @(negedge clk);
    pin_rst_n = 1'h1;
    repeat (4) @(negedge clk);
  endtask
  // ********
  // tests
  // ********
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'hF1A1));
    repeat (2) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    key(64, -1);
    chk(unlocked, 1'h1);
    t_w = rand_time(8'h21);
    xfer(1'h0, t_w | ~TIME_KEEP_MASK, t_r);
    chk(unlocked, 1'h0);
    chk(osc_on, 1'h0);
    key(64, -1);
    xfer(1'h1, '0, t_r);
    chk(t_r, t_w);
    host.cyc(1'h1, 1'h1, 1'h0, r, m);
    chk(m, 1'h0);
    key(1 + $urandom % 63, -1);
    key(64, -1);
    chk(unlocked, 1'h1);
    pin_reset();
    chk(unlocked, 1'h0);
    key(64, $urandom % 64);
    chk(unlocked, 1'h0);
    key(64, -1);
    pf = 1'h1;
    repeat (8) @(negedge clk);
    chk(unlocked, 1'h0);
    key(64, -1);
    chk(unlocked, 1'h0);
    pf = 1'h0;
    repeat (4) @(negedge clk);
    key(64, -1);
    xfer(1'h1, '0, t_r);
    chk(t_r, t_w);
    key(64, -1);
    t_w = rand_time(8'h31);
    t_w.hour = 8'hB1;
    xfer(1'h0, t_w, t_r);
    key(64, -1);
    pin_reset();
    chk(unlocked, 1'h1);
    xfer(1'h1, '0, t_r);
    chk(t_r, t_w);
    key(64, -1);
    t_w = rand_time(8'h11);
    xfer(1'h0, t_w, t_r);
    chk(osc_on, 1'h1);
    key(64, -1);
    xfer(1'h1, '0, t_r);
    chk(digits_ok(t_r), 1'h1);
    chk(t_r != t_w, 1'h1);
    test_done();
  end
endmodule
bind rsrtc_top rsrtc_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST), .I_CE_N(I_CE_N), .I_OE_N(I_OE_N),
  .I_DIRECTION_SELECT_LINE(I_DIRECTION_SELECT_LINE),
  .I_SERIAL_WRITE_BIT_LINE(I_SERIAL_WRITE_BIT_LINE),
  .I_UPPER_ADDRESS_RESET_N(I_UPPER_ADDRESS_RESET_N), .I_POWER_FAIL(I_POWER_FAIL),
  .O_SERIAL_READ_BIT_LINE(O_SERIAL_READ_BIT_LINE),
  .O_SERIAL_READ_BIT_LINE_OE_N(O_SERIAL_READ_BIT_LINE_OE_N), .O_MEM_CE_N(O_MEM_CE_N),
  .O_UNLOCKED(O_UNLOCKED), .O_OSC_RUNNING(O_OSC_RUNNING));
